/* tb/pllf_loop_regs_assertions.sv */
// concurrent checks on the loop filter register bank ports
`timescale 1ns/1ps
`default_nettype none
module pllf_loop_regs_assertions (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic nvm_ld_i,
    input wire logic [7:0] nvm_addr_i,
    input wire logic [7:0] nvm_data_i,
    input wire logic [2:0] pump_phase_delay_sel_o,
    input wire logic pump_delay_50mhz_o,
    input wire logic third_pole_cap_enable_o,
    input wire logic [7:0] zero_resistor_code_o,
    input wire logic [2:0] main_capacitor_code_o,
    input wire logic [6:0] pole_resistor_code_o,
    input wire logic [2:0] pole_capacitor_code_o,
    input wire logic [8:0] main_cap_pf_o,
    input wire logic [5:0] pole_cap_pf_o
);
    // one domain, so clock and async reset are given once
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read strobe got no valid pulse");
    stray_valid_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("valid pulse without a read");
    read_hold_a: assert property (
        !reg_rvalid_o |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
    cap_rsv_a: assert property (reg_rd_i && (reg_addr_i == 8'h25 ||
        reg_addr_i == 8'h27) |=> reg_rdata_o[7:3] == 5'h00)
    else $error("capacitor reserved bits read nonzero");
    delay_grade_a: assert property (
        pump_delay_50mhz_o == pump_phase_delay_sel_o[2])
    else $error("delay grade flag disagrees with select");
    main_pf_a: assert property (
        main_cap_pf_o == 9'h005 + 9'h032 * main_capacitor_code_o)
    else $error("main capacitance wrong for code");
    pole_pf_a: assert property (
        pole_cap_pf_o == 6'h05 * pole_capacitor_code_o)
    else $error("pole capacitance wrong for code");
    ctrl_write_a: assert property (
        reg_wr_i && reg_addr_i == 8'h23 |-> ##2
        (pump_phase_delay_sel_o == $past(reg_wdata_i[6:4], 2) &&
        third_pole_cap_enable_o == $past(reg_wdata_i[2], 2)))
    else $error("control write not applied");
    pcap_write_a: assert property (
        reg_wr_i && reg_addr_i == 8'h27 |-> ##2
        pole_capacitor_code_o == $past(reg_wdata_i[2:0], 2))
    else $error("pole capacitor write not applied");
    nvm_zres_a: assert property (nvm_ld_i && nvm_addr_i == 8'h24 &&
        !(reg_wr_i && reg_addr_i == 8'h24) |-> ##2
        zero_resistor_code_o == $past(nvm_data_i, 2))
    else $error("stored zero resistor code not loaded");
    nvm_ctrl_a: assert property (nvm_ld_i && nvm_addr_i == 8'h23 &&
        !(reg_wr_i && reg_addr_i == 8'h23) |-> ##2
        (pump_phase_delay_sel_o == $past(nvm_data_i[6:4], 2) &&
        third_pole_cap_enable_o == $past(nvm_data_i[2], 2)))
    else $error("stored control byte not loaded");
endmodule // pllf_loop_regs_assertions
bind pllf_loop_regs pllf_loop_regs_assertions i_chk (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .nvm_ld_i(nvm_ld_i), .nvm_addr_i(nvm_addr_i), .nvm_data_i(nvm_data_i),
    .pump_phase_delay_sel_o(pump_phase_delay_sel_o),
    .pump_delay_50mhz_o(pump_delay_50mhz_o),
    .third_pole_cap_enable_o(third_pole_cap_enable_o),
    .zero_resistor_code_o(zero_resistor_code_o),
    .main_capacitor_code_o(main_capacitor_code_o),
    .pole_resistor_code_o(pole_resistor_code_o),
    .pole_capacitor_code_o(pole_capacitor_code_o),
    .main_cap_pf_o(main_cap_pf_o), .pole_cap_pf_o(pole_cap_pf_o));
`default_nettype wire

/* tb/pllf_loop_regs_tb_top.sv */
// self-checking bench for the loop filter register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    miscompares++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module pllf_loop_regs_tb_top;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_rd_i = 1'b0;
    logic nvm_ld_i = 1'b0;
    logic [7:0] nvm_addr_i = 8'h00;
    logic [7:0] nvm_data_i = 8'h00;
    wire [7:0] reg_rdata_o, zres;
    wire reg_rvalid_o, flag50, c3en;
    wire [2:0] phase, mcap, pcap;
    wire [6:0] pres;
    wire [8:0] mpf;
    wire [5:0] ppf;
    int miscompares = 0;
    int cmp_count = 0;
    pllf_loop_regs i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .nvm_ld_i(nvm_ld_i),
        .nvm_addr_i(nvm_addr_i), .nvm_data_i(nvm_data_i),
        .pump_phase_delay_sel_o(phase), .pump_delay_50mhz_o(flag50),
        .third_pole_cap_enable_o(c3en), .zero_resistor_code_o(zres),
        .main_capacitor_code_o(mcap), .pole_resistor_code_o(pres),
        .pole_capacitor_code_o(pcap), .main_cap_pf_o(mpf),
        .pole_cap_pf_o(ppf));
    // 200 MHz clock
    always #2.5 sys_clk_i = ~sys_clk_i;
    ////////////////////////////////////////////////////////////////////
    // write, then wait until the field outputs have caught up
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
    endtask
    // read one byte; valid stands for one cycle only, so compare it at the
    // falling edge right after the strobe edge, then drop the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] ex);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge sys_clk_i);
        `CHK("rvalid", 1'b1, reg_rvalid_o)
        `CHK("rdata", ex, reg_rdata_o)
        reg_rd_i = 1'b0;
    endtask
    task automatic t_reset();
        `CHK("phase", 3'h2, phase)
        `CHK("flag50", 1'b0, flag50)
        `CHK("c3en", 1'b1, c3en)
        `CHK("zres", 8'h24, zres)
        `CHK("mcap", 3'h2, mcap)
        `CHK("mpf", 9'h069, mpf)
        `CHK("pres", 7'h00, pres)
        `CHK("pcap", 3'h7, pcap)
        `CHK("ppf", 6'h23, ppf)
        rdc(8'h23, 8'h27);
        rdc(8'h24, 8'h24);
        rdc(8'h25, 8'h02);
        rdc(8'h26, 8'h00);
        rdc(8'h27, 8'h07);
        $display("test reset done");
    endtask
    // every delay code, reserved bits written as ones, third pole cleared
    task automatic t_phase();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(8'h23, {1'b1, c, 4'b1011});
            `CHK("phase", c, phase)
            `CHK("flag50", c[2], flag50)
            `CHK("c3en", 1'b0, c3en)
            rdc(8'h23, {1'b0, c, 4'b0011});
        end
        wr(8'h23, 8'h07);
        `CHK("c3en", 1'b1, c3en)
        $display("test phase done");
    endtask
    // every capacitor code, reserved upper bits must read back zero
    task automatic t_caps();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(8'h25, {5'h1F, c});
            wr(8'h27, {5'h1F, c});
            `CHK("mcap", c, mcap)
            `CHK("mpf", 9'(5 + 50 * i), mpf)
            `CHK("pcap", c, pcap)
            `CHK("ppf", 6'(5 * i), ppf)
            rdc(8'h25, {5'h00, c});
            rdc(8'h27, {5'h00, c});
        end
        $display("test caps done");
    endtask
    // listed and unlisted resistor codes, plus the pole reserved bit
    task automatic t_res();
        wr(8'h24, 8'h01);
        `CHK("zres", 8'h01, zres)
        wr(8'h24, 8'hFF);
        `CHK("zres", 8'hFF, zres)
        wr(8'h26, 8'hFF);
        `CHK("pres", 7'h7F, pres)
        rdc(8'h26, 8'h7F);
        wr(8'h26, 8'h14);
        `CHK("pres", 7'h14, pres)
        $display("test res done");
    endtask
    // back-to-back loads, one colliding with a software write
    task automatic t_nvm();
        @(negedge sys_clk_i);
        nvm_ld_i = 1'b1;
        nvm_addr_i = 8'h24;
        nvm_data_i = 8'h40;
        @(negedge sys_clk_i);
        nvm_addr_i = 8'h26;
        nvm_data_i = 8'h03;
        @(negedge sys_clk_i);
        nvm_addr_i = 8'h27;
        nvm_data_i = 8'h01;
        reg_addr_i = 8'h27;
        reg_wdata_i = 8'h06;
        reg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        nvm_ld_i = 1'b0;
        reg_wr_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        `CHK("zres", 8'h40, zres)
        `CHK("pres", 7'h03, pres)
        `CHK("ppf", 6'h1E, ppf)
        wr(8'h24, 8'h30);
        `CHK("zres", 8'h30, zres)
        // unmapped places take nothing and read zero
        wr(8'h28, 8'hAA);
        wr(8'h22, 8'hFF);
        rdc(8'h28, 8'h00);
        rdc(8'h22, 8'h00);
        `CHK("zres", 8'h30, zres)
        // startup loads of the control byte and both capacitor codes,
        // reserved control bits set in the stored byte must read zero
        @(negedge sys_clk_i);
        nvm_ld_i = 1'b1;
        nvm_addr_i = 8'h23;
        nvm_data_i = 8'hD8;
        @(negedge sys_clk_i);
        nvm_addr_i = 8'h25;
        nvm_data_i = 8'hFD;
        @(negedge sys_clk_i);
        nvm_addr_i = 8'h27;
        nvm_data_i = 8'h0C;
        @(negedge sys_clk_i);
        nvm_ld_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        `CHK("phase", 3'h5, phase)
        `CHK("flag50", 1'b1, flag50)
        `CHK("c3en", 1'b0, c3en)
        `CHK("mcap", 3'h5, mcap)
        `CHK("mpf", 9'h0FF, mpf)
        `CHK("pcap", 3'h4, pcap)
        `CHK("ppf", 6'h14, ppf)
        rdc(8'h23, 8'h50);
        $display("test nvm done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // watchdog: the tests need well under 1000 cycles
    initial begin
        #20000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (4) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        t_reset();
        t_phase();
        t_caps();
        t_res();
        t_nvm();
        // second reset in mid-run must restore every default
        @(negedge sys_clk_i);
        rstn_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        t_reset();
        wrap_up();
    end
endmodule // pllf_loop_regs_tb_top
`default_nettype wire

/* verilog/pllf_field_reg.v */
// one configuration field: reset value, startup load and software write
`timescale 1ns/1ps
`default_nettype none

module pllf_field_reg #(
    parameter integer W = 8,        // field width in bits
    parameter [7:0] RST = 8'h00     // reset value, low W bits used
) (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire wr_i,                // software write strobe
    input wire [W-1:0] wdata_i,     // software write data
    input wire ld_i,                // nonvolatile load strobe
    input wire [W-1:0] ld_data_i,   // nonvolatile load data
    output wire [W-1:0] q_o         // current field value
);

    reg [W-1:0] q_r;    // stored field
    reg [W-1:0] q_nxt;  // next field value

    // software write wins over a load in the same cycle, since the
    // later intent of software must not be silently undone
    always @* begin
        q_nxt = q_r;
        if (wr_i) begin
            q_nxt = wdata_i;
        end else if (ld_i) begin
            q_nxt = ld_data_i;
        end
    end

    // field storage, constant reset value
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q_r <= RST[W-1:0];
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;

endmodule // pllf_field_reg

`default_nettype wire

/* verilog/pllf_loop_regs.v */
// loop filter and charge pump configuration register bank
//
// What this block does
// - 3-bit pump phase delay select, reset 2
// - third pole capacitor enable bit, reset 1
// - 8-bit zero resistor code, reset 0x24
// - 3-bit main capacitor code, 5+50*code pF
// - 7-bit pole resistor code, reset 0x00
// - 3-bit pole capacitor code, 5*code pF
// - reserved bits hold nothing, read zero, except control bits 1:0, which are stored and read back
`timescale 1ns/1ps
`default_nettype none
`include "pllf_regs.vh"

module pllf_loop_regs (
    input wire sys_clk_i,           // register clock
    input wire rstn_i,              // async reset, active low
    input wire [7:0] reg_addr_i,    // register offset from control port
    input wire reg_wr_i,            // write strobe, one cycle
    input wire [7:0] reg_wdata_i,   // write data
    input wire reg_rd_i,            // read strobe, one cycle
    output wire [7:0] reg_rdata_o,  // read data, registered
    output wire reg_rvalid_o,       // read data valid pulse
    input wire nvm_ld_i,            // startup load strobe, one cycle
    input wire [7:0] nvm_addr_i,    // offset of the byte being loaded
    input wire [7:0] nvm_data_i,    // byte being loaded
    output wire [2:0] pump_phase_delay_sel_o,
    output wire pump_delay_50mhz_o, // high when a 50 MHz grade delay
    output wire third_pole_cap_enable_o,
    output wire [7:0] zero_resistor_code_o,
    output wire [2:0] main_capacitor_code_o,
    output wire [6:0] pole_resistor_code_o,
    output wire [2:0] pole_capacitor_code_o,
    output wire [8:0] main_cap_pf_o,  // selected main capacitance, pF
    output wire [5:0] pole_cap_pf_o   // selected pole capacitance, pF
);

    ////////////////////////////////////////////////////////////////////
    // address decode
    ////////////////////////////////////////////////////////////////////

    // write strobes per register, unmapped offsets fall through
    wire wr_ctrl = reg_wr_i && (reg_addr_i == `PLLF_OFS_LOOP_CTRL);
    wire wr_zres = reg_wr_i && (reg_addr_i == `PLLF_OFS_ZERO_RES);
    wire wr_mcap = reg_wr_i && (reg_addr_i == `PLLF_OFS_MAIN_CAP);
    wire wr_pres = reg_wr_i && (reg_addr_i == `PLLF_OFS_POLE_RES);
    wire wr_pcap = reg_wr_i && (reg_addr_i == `PLLF_OFS_POLE_CAP);

    // load strobes per register from nonvolatile storage
    wire ld_ctrl = nvm_ld_i && (nvm_addr_i == `PLLF_OFS_LOOP_CTRL);
    wire ld_zres = nvm_ld_i && (nvm_addr_i == `PLLF_OFS_ZERO_RES);
    wire ld_mcap = nvm_ld_i && (nvm_addr_i == `PLLF_OFS_MAIN_CAP);
    wire ld_pres = nvm_ld_i && (nvm_addr_i == `PLLF_OFS_POLE_RES);
    wire ld_pcap = nvm_ld_i && (nvm_addr_i == `PLLF_OFS_POLE_CAP);

    ////////////////////////////////////////////////////////////////////
    // field storage
    ////////////////////////////////////////////////////////////////////

    wire [2:0] phase_q;   // pump phase delay select
    wire c3en_q;          // third pole capacitor enable
    wire [1:0] rsv_q;     // loop control low bits, kept at 11 by software
    wire [7:0] zres_q;    // zero resistor code
    wire [2:0] mcap_q;    // main capacitor code
    wire [6:0] pres_q;    // pole resistor code
    wire [2:0] pcap_q;    // pole capacitor code

    // code 0 no delay, 1..3 graded for 100 MHz, 4..7 for 50 MHz
    pllf_field_reg #(.W(`PLLF_PHASE_W), .RST(`PLLF_RST_PHASE)) u_phase (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .wr_i(wr_ctrl),
        .wdata_i(reg_wdata_i[`PLLF_PHASE_MSB:`PLLF_PHASE_LSB]),
        .ld_i(ld_ctrl),
        .ld_data_i(nvm_data_i[`PLLF_PHASE_MSB:`PLLF_PHASE_LSB]),
        .q_o(phase_q)
    );

    // 1 switches the third capacitor in, 0 gives a second order filter;
    // the reset value stays 1 even though 0 is the preferred setting,
    // clearing it is left to software
    pllf_field_reg #(.W(1), .RST(`PLLF_RST_C3EN)) u_c3en (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .wr_i(wr_ctrl),
        .wdata_i(reg_wdata_i[`PLLF_C3EN_BIT]),
        .ld_i(ld_ctrl),
        .ld_data_i(nvm_data_i[`PLLF_C3EN_BIT]),
        .q_o(c3en_q)
    );

    // low control bits have storage backing, so they are held as written
    pllf_field_reg #(.W(`PLLF_RSV_W), .RST(`PLLF_RST_CTRL_RSV)) u_rsv (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .wr_i(wr_ctrl),
        .wdata_i(reg_wdata_i[`PLLF_CTRL_RSV_MSB:`PLLF_CTRL_RSV_LSB]),
        .ld_i(ld_ctrl),
        .ld_data_i(nvm_data_i[`PLLF_CTRL_RSV_MSB:`PLLF_CTRL_RSV_LSB]),
        .q_o(rsv_q)
    );

    // every code is accepted, not only the tabulated ones
    pllf_field_reg #(.W(`PLLF_ZRES_W), .RST(`PLLF_RST_ZERO_RES)) u_zres (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .wr_i(wr_zres),
        .wdata_i(reg_wdata_i[`PLLF_ZRES_W-1:0]),
        .ld_i(ld_zres),
        .ld_data_i(nvm_data_i[`PLLF_ZRES_W-1:0]),
        .q_o(zres_q)
    );

    // main capacitor code, upper bits of the byte are dropped
    pllf_field_reg #(.W(`PLLF_MCAP_W), .RST(`PLLF_RST_MAIN_CAP)) u_mcap (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .wr_i(wr_mcap),
        .wdata_i(reg_wdata_i[`PLLF_MCAP_W-1:0]),
        .ld_i(ld_mcap),
        .ld_data_i(nvm_data_i[`PLLF_MCAP_W-1:0]),
        .q_o(mcap_q)
    );

    // pole resistor code, any of the 128 codes is stored
    pllf_field_reg #(.W(`PLLF_PRES_W), .RST(`PLLF_RST_POLE_RES)) u_pres (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .wr_i(wr_pres),
        .wdata_i(reg_wdata_i[`PLLF_PRES_W-1:0]),
        .ld_i(ld_pres),
        .ld_data_i(nvm_data_i[`PLLF_PRES_W-1:0]),
        .q_o(pres_q)
    );

    // pole capacitor code, zero selects no capacitance
    pllf_field_reg #(.W(`PLLF_PCAP_W), .RST(`PLLF_RST_POLE_CAP)) u_pcap (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .wr_i(wr_pcap),
        .wdata_i(reg_wdata_i[`PLLF_PCAP_W-1:0]),
        .ld_i(ld_pcap),
        .ld_data_i(nvm_data_i[`PLLF_PCAP_W-1:0]),
        .q_o(pcap_q)
    );

    ////////////////////////////////////////////////////////////////////
    // readback
    ////////////////////////////////////////////////////////////////////

    reg [7:0] rdata_nxt;   // byte selected by the read offset
    reg [7:0] rdata_r;     // registered read data
    reg rvalid_r;          // read data valid pulse

    // reserved positions other than control bits 1:0 read as zero; unmapped offsets read 00
    always @* begin
        rdata_nxt = 8'h00;
        case (reg_addr_i)
            `PLLF_OFS_LOOP_CTRL: begin
                rdata_nxt = {1'b0, phase_q, 1'b0, c3en_q, rsv_q};
            end
            `PLLF_OFS_ZERO_RES: begin
                rdata_nxt = zres_q;
            end
            `PLLF_OFS_MAIN_CAP: begin
                rdata_nxt = {5'h00, mcap_q};
            end
            `PLLF_OFS_POLE_RES: begin
                rdata_nxt = {1'b0, pres_q};
            end
            `PLLF_OFS_POLE_CAP: begin
                rdata_nxt = {5'h00, pcap_q};
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    // read data is captured on the strobe and held until the next read
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd_i;
            if (reg_rd_i) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // analog control outputs
    ////////////////////////////////////////////////////////////////////

    reg [2:0] phase_r;    // registered copy of phase delay select
    reg delay50_r;        // 50 MHz grade flag
    reg c3en_r;           // third pole enable to the filter
    reg [7:0] zres_r;     // zero resistor code to the filter
    reg [2:0] mcap_r;     // main capacitor code to the filter
    reg [6:0] pres_r;     // pole resistor code to the filter
    reg [2:0] pcap_r;     // pole capacitor code to the filter
    reg [8:0] mcap_pf_r;  // main capacitance in pF
    reg [5:0] pcap_pf_r;  // pole capacitance in pF

    // scaled values, widths sized so nothing is cut: 5+50*7 = 355
    wire [8:0] mcap_pf_nxt = `PLLF_MCAP_BASE_PF +
        `PLLF_MCAP_STEP_PF * {6'h00, mcap_q};
    wire [5:0] pcap_pf_nxt = `PLLF_PCAP_STEP_PF * {3'h0, pcap_q};

    // outputs are retimed so the analog side sees only flop edges;
    // this costs one cycle of latency after a write, harmless here.
    // after reset the copies equal the field reset values
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_r <= 3'h2;
            delay50_r <= 1'b0;
            c3en_r <= 1'b1;
            zres_r <= 8'h24;
            mcap_r <= 3'h2;
            pres_r <= 7'h00;
            pcap_r <= 3'h7;
            mcap_pf_r <= 9'h069;
            pcap_pf_r <= 6'h23;
        end else begin
            phase_r <= phase_q;
            delay50_r <= phase_q[2];
            c3en_r <= c3en_q;
            zres_r <= zres_q;
            mcap_r <= mcap_q;
            pres_r <= pres_q;
            pcap_r <= pcap_q;
            mcap_pf_r <= mcap_pf_nxt;
            pcap_pf_r <= pcap_pf_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;
    assign pump_phase_delay_sel_o = phase_r;
    assign pump_delay_50mhz_o = delay50_r;
    assign third_pole_cap_enable_o = c3en_r;
    assign zero_resistor_code_o = zres_r;
    assign main_capacitor_code_o = mcap_r;
    assign pole_resistor_code_o = pres_r;
    assign pole_capacitor_code_o = pcap_r;
    assign main_cap_pf_o = mcap_pf_r;
    assign pole_cap_pf_o = pcap_pf_r;

endmodule // pllf_loop_regs

`default_nettype wire

/* verilog/pllf_regs.vh */
// register offsets, field positions, reset values and scale figures
`ifndef PLLF_REGS_VH
`define PLLF_REGS_VH

// register byte offsets on the control port
`define PLLF_OFS_LOOP_CTRL 8'h23
`define PLLF_OFS_ZERO_RES 8'h24
`define PLLF_OFS_MAIN_CAP 8'h25
`define PLLF_OFS_POLE_RES 8'h26
`define PLLF_OFS_POLE_CAP 8'h27

// loop control register field positions
`define PLLF_PHASE_MSB 6
`define PLLF_PHASE_LSB 4
`define PLLF_C3EN_BIT 2
`define PLLF_CTRL_RSV_MSB 1
`define PLLF_CTRL_RSV_LSB 0

// field widths
`define PLLF_PHASE_W 3
`define PLLF_RSV_W 2
`define PLLF_ZRES_W 8
`define PLLF_MCAP_W 3
`define PLLF_PRES_W 7
`define PLLF_PCAP_W 3

// field reset values
`define PLLF_RST_PHASE 8'h02
`define PLLF_RST_C3EN 8'h01
`define PLLF_RST_CTRL_RSV 8'h03
`define PLLF_RST_ZERO_RES 8'h24
`define PLLF_RST_MAIN_CAP 8'h02
`define PLLF_RST_POLE_RES 8'h00
`define PLLF_RST_POLE_CAP 8'h07

// capacitance scale in pF
`define PLLF_MCAP_BASE_PF 9'h005
`define PLLF_MCAP_STEP_PF 9'h032
`define PLLF_PCAP_STEP_PF 6'h05

`endif
